// file: core/fpx_map.vh
// constants for the auxiliary floating-point execution block
`ifndef FPX_MAP_VH
`define FPX_MAP_VH
// ----------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define FPX_OFF_TRAPS 8'h00
`define FPX_OFF_SF0 8'h04
`define FPX_OFF_SF1 8'h08
`define FPX_OFF_SF2 8'h0C
`define FPX_OFF_SF3 8'h10
`define FPX_OFF_REG_SEL 8'h14
`define FPX_OFF_REG_W0 8'h18
`define FPX_OFF_REG_W1 8'h1C
`define FPX_OFF_REG_W2 8'h20
`define FPX_OFF_STATUS 8'h24
// ----------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------
`define FPX_SF_CTRL_LSB 0
`define FPX_SF_FLAG_LSB 7
`define FPX_TRAPS_RST 6'h00
`define FPX_CTRL_RST 7'h00
`define FPX_FLAG_INVALID 6'h01
// ----------------------------------------------------------------
// register-format encodings
// ----------------------------------------------------------------
`define FPX_EXP_MAX 17'h1FFFF
`define FPX_EXP_INT 17'h1003E
`define FPX_EXP_ONE 17'h0FFFF
`define FPX_SGL_BIAS 17'h0FF80
`define FPX_ZERO 82'h0
`define FPX_ONE {1'b0, `FPX_EXP_ONE, 64'h8000000000000000}
`define FPX_NAT_VALUE {1'b0, 17'h1FFFE, 64'h0}
// ----------------------------------------------------------------
// arithmetic kinds sent to the fused multiply-add unit
// ----------------------------------------------------------------
`define FPX_K_MA 2'h0
`define FPX_K_MS 2'h1
`define FPX_K_NMA 2'h2
// ----------------------------------------------------------------
// operation codes
// ----------------------------------------------------------------
`define FPX_OP_FMA 6'h00
`define FPX_OP_FMS 6'h01
`define FPX_OP_FNMA 6'h02
`define FPX_OP_PMA 6'h03
`define FPX_OP_PMS 6'h04
`define FPX_OP_PNMA 6'h05
`define FPX_OP_MPY 6'h06
`define FPX_OP_PMPY 6'h07
`define FPX_OP_NMPY 6'h08
`define FPX_OP_PNMPY 6'h09
`define FPX_OP_ADD 6'h0A
`define FPX_OP_SUB 6'h0B
`define FPX_OP_NEGATE 6'h0C
`define FPX_OP_NORM 6'h0D
`define FPX_OP_CVT_UF 6'h0E
`define FPX_OP_ABS 6'h10
`define FPX_OP_NEG 6'h11
`define FPX_OP_NEGABS 6'h12
`define FPX_OP_MRG_SIGN 6'h13
`define FPX_OP_MRG_NEG_SIGN 6'h14
`define FPX_OP_MRG_SIGN_EXP 6'h15
`define FPX_OP_CLASS 6'h16
`define FPX_OP_MIX_L 6'h17
`define FPX_OP_MIX_R 6'h18
`define FPX_OP_MIX_LR 6'h19
`define FPX_OP_SXT_L 6'h1A
`define FPX_OP_SXT_R 6'h1B
`define FPX_OP_PACK 6'h1C
`define FPX_OP_SWAP 6'h1D
`define FPX_OP_SWAP_NL 6'h1E
`define FPX_OP_SWAP_NR 6'h1F
`define FPX_OP_AND 6'h20
`define FPX_OP_ANDCM 6'h21
`define FPX_OP_OR 6'h22
`define FPX_OP_XOR 6'h23
`define FPX_OP_SELECT 6'h24
`define FPX_OP_CHK_FLAGS 6'h25
`define FPX_OP_CLR_FLAGS 6'h26
`define FPX_OP_SET_CTRL 6'h27
`define FPX_OP_IMA_L 6'h28
`define FPX_OP_IMA_H 6'h29
`define FPX_OP_IMA_LU 6'h2A
`define FPX_OP_IMA_HU 6'h2B
`endif

// file: core/fpx_unit.v
// auxiliary floating-point execution unit with wishbone register access
`include "fpx_map.vh"
`timescale 1ns/100ps
`default_nettype none
module fpx_unit (
   input wire clock_i,
   input wire resetn_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output wire [31:0] wb_dat_o,
   output wire wb_ack_o,
   input wire op_valid_i,
   output wire op_ready_o,
   input wire [5:0] op_code_i,
   input wire [2:0] op_f1_i,
   input wire [2:0] op_f2_i,
   input wire [2:0] op_f3_i,
   input wire [2:0] op_f4_i,
   input wire [1:0] op_sf_i,
   input wire [13:0] op_imm_i,
   output wire op_done_o,
   output wire op_fault_o,
   output wire op_pred_o,
   output wire arith_valid_o,
   output wire [1:0] arith_kind_o,
   output wire arith_packed_o,
   output wire [81:0] arith_a_o,
   output wire [81:0] arith_b_o,
   output wire [81:0] arith_c_o,
   output wire [1:0] arith_sf_o,
   output wire [6:0] arith_ctrl_o,
   input wire arith_done_i,
   input wire [81:0] arith_result_i,
   input wire [5:0] arith_flags_i
);
   localparam ST_IDLE = 2'b01;
   localparam ST_ARITH = 2'b10;
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function [81:0] fpx_int;
      input [63:0] sig;
      fpx_int = {1'b0, `FPX_EXP_INT, sig};
   endfunction
   // class set: nat,qnan,snan,inf,norm,unnorm,zero,neg,pos
   function [8:0] fpx_cls;
      input [81:0] x;
      reg nat;
      reg top;
      reg nan;
      begin
         nat = (x == `FPX_NAT_VALUE);
         top = (x[80:64] == `FPX_EXP_MAX);
         nan = top && (x[62:0] != 63'h0);
         fpx_cls[8] = nat;
         fpx_cls[7] = nan && x[62];
         fpx_cls[6] = nan && !x[62];
         fpx_cls[5] = top && (x[62:0] == 63'h0);
         fpx_cls[4] = !top && x[63];
         fpx_cls[3] = !top && !x[63] && (x[62:0] != 63'h0);
         fpx_cls[2] = !nat && (x[63:0] == 64'h0);
         fpx_cls[1] = x[81];
         fpx_cls[0] = !x[81];
      end
   endfunction
   // truncating narrow to single; range overflow is not clamped
   function [31:0] fpx_sgl;
      input [81:0] x;
      reg [16:0] e;
      begin
         e = x[80:64] - `FPX_SGL_BIAS;
         fpx_sgl = {x[81], (x[80:64] == 17'h0) ? 8'h00 : e[7:0], x[62:40]};
      end
   endfunction
   function [31:0] fpx_be;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] sel;
      integer b;
      begin
         fpx_be = old;
         for (b = 0; b < 4; b = b + 1) begin
            if (sel[b]) begin
               fpx_be[b*8 +: 8] = nw[b*8 +: 8];
            end
         end
      end
   endfunction
   function [5:0] fpx_f6;
      input [23:0] v;
      input [1:0] s;
      fpx_f6 = v[s*6 +: 6];
   endfunction
   function [6:0] fpx_f7;
      input [27:0] v;
      input [1:0] s;
      fpx_f7 = v[s*7 +: 7];
   endfunction
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   reg [81:0] fr_q [2:7];
   reg [1:0] state_q;
   reg ready_q;
   reg done_q;
   reg fault_q;
   reg pred_q;
   reg av_q;
   reg [1:0] kind_q;
   reg pk_q;
   reg [81:0] a_q;
   reg [81:0] b_q;
   reg [81:0] c_q;
   reg [1:0] sf_q;
   reg [2:0] dest_q;
   reg [6:0] actl_q;
   reg [5:0] traps_q;
   reg [5:0] traps_d;
   reg [27:0] ctrl_q;
   reg [27:0] ctrl_d;
   reg [23:0] flags_q;
   reg [23:0] flags_d;
   reg [2:0] rsel_q;
   reg [31:0] w0_q;
   reg [31:0] w1_q;
   reg ack_q;
   reg [31:0] dat_q;
   reg [31:0] rd_d;
   wire [81:0] rdv [0:7];
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : rd
         if (g == 0) begin : z
            assign rdv[g] = `FPX_ZERO;
         end else if (g == 1) begin : o
            assign rdv[g] = `FPX_ONE;
         end else begin : r
            assign rdv[g] = fr_q[g];
         end
      end
   endgenerate
   // ----------------------------------------------------------------
   // decode and operand remapping
   // ----------------------------------------------------------------
   reg [2:0] i2;
   reg [2:0] i4;
   reg [1:0] kind;
   reg pk;
   reg wr;
   wire idle = state_q[0];
   wire accept = idle && op_valid_i;
   wire is_ar = (op_code_i <= `FPX_OP_CVT_UF);
   always @* begin
      i2 = op_f2_i;
      i4 = op_f4_i;
      case (op_code_i)
         `FPX_OP_MPY, `FPX_OP_PMPY, `FPX_OP_NMPY, `FPX_OP_PNMPY: i2 = 3'h0;
         `FPX_OP_NEGATE, `FPX_OP_NORM, `FPX_OP_CVT_UF: i2 = 3'h0;
         `FPX_OP_ABS, `FPX_OP_NEGABS: i2 = 3'h0;
         `FPX_OP_NEG: i2 = op_f3_i;
         default: i2 = op_f2_i;
      endcase
      case (op_code_i)
         `FPX_OP_ADD, `FPX_OP_SUB: i4 = 3'h1;
         `FPX_OP_NEGATE, `FPX_OP_NORM, `FPX_OP_CVT_UF: i4 = 3'h1;
         default: i4 = op_f4_i;
      endcase
      case (op_code_i)
         `FPX_OP_FMS, `FPX_OP_PMS, `FPX_OP_SUB: kind = `FPX_K_MS;
         `FPX_OP_FNMA, `FPX_OP_PNMA, `FPX_OP_NMPY, `FPX_OP_PNMPY: kind = `FPX_K_NMA;
         `FPX_OP_NEGATE: kind = `FPX_K_NMA;
         default: kind = `FPX_K_MA;
      endcase
      case (op_code_i)
         `FPX_OP_PMA, `FPX_OP_PMS, `FPX_OP_PNMA, `FPX_OP_PMPY, `FPX_OP_PNMPY: pk = 1'b1;
         default: pk = 1'b0;
      endcase
      case (op_code_i)
         `FPX_OP_CLASS, `FPX_OP_CHK_FLAGS, `FPX_OP_CLR_FLAGS, `FPX_OP_SET_CTRL: wr = 1'b0;
         default: wr = (op_code_i <= `FPX_OP_IMA_HU) && (op_code_i != 6'h0F);
      endcase
   end
   wire [81:0] v2 = rdv[i2];
   wire [81:0] v3 = rdv[op_f3_i];
   wire [81:0] v4 = rdv[i4];
   wire [8:0] c2 = fpx_cls(v2);
   wire [8:0] c3 = fpx_cls(v3);
   wire [8:0] c4 = fpx_cls(v4);
   wire use4 = is_ar || (op_code_i == `FPX_OP_SELECT) || (op_code_i >= `FPX_OP_IMA_L);
   wire nat_any = c2[8] || c3[8] || (use4 && c4[8]);
   wire n2 = c2[7] || c2[6];
   wire n3 = c3[7] || c3[6];
   wire n4 = c4[7] || c4[6];
   // packed pairs carry their own NaNs inside the significand
   wire nan_cut = is_ar && !pk && (n2 || n3 || n4);
   wire ar_go = is_ar && !nan_cut && !nat_any;
   wire snan_any = c2[6] || c3[6] || c4[6];
   wire [81:0] nan_pick = n4 ? v4 : (n2 ? v2 : v3);
   // ----------------------------------------------------------------
   // integer multiply-add: sign and exponent fields never enter
   // ----------------------------------------------------------------
   wire ima_sgn = (op_code_i == `FPX_OP_IMA_L) || (op_code_i == `FPX_OP_IMA_H);
   wire [127:0] ea = {(ima_sgn ? {64{v3[63]}} : 64'h0), v3[63:0]};
   wire [127:0] eb = {(ima_sgn ? {64{v4[63]}} : 64'h0), v4[63:0]};
   wire [127:0] ima_r = ea * eb + {64'h0, v2[63:0]};
   // ----------------------------------------------------------------
   // non-arithmetic result, always at full register width
   // ----------------------------------------------------------------
   reg [81:0] res;
   always @* begin
      case (op_code_i)
         `FPX_OP_ABS, `FPX_OP_MRG_SIGN: res = {v2[81], v3[80:0]};
         `FPX_OP_NEG, `FPX_OP_NEGABS, `FPX_OP_MRG_NEG_SIGN: res = {~v2[81], v3[80:0]};
         `FPX_OP_MRG_SIGN_EXP: res = {v2[81:64], v3[63:0]};
         `FPX_OP_MIX_L: res = fpx_int({v2[63:32], v3[63:32]});
         `FPX_OP_MIX_R: res = fpx_int({v2[31:0], v3[31:0]});
         `FPX_OP_MIX_LR: res = fpx_int({v2[63:32], v3[31:0]});
         `FPX_OP_SXT_L: res = fpx_int({{32{v2[63]}}, v3[63:32]});
         `FPX_OP_SXT_R: res = fpx_int({{32{v2[31]}}, v3[31:0]});
         `FPX_OP_PACK: res = fpx_int({fpx_sgl(v2), fpx_sgl(v3)});
         `FPX_OP_SWAP: res = fpx_int({v2[31:0], v3[63:32]});
         `FPX_OP_SWAP_NL: res = fpx_int({~v2[31], v2[30:0], v3[63:32]});
         `FPX_OP_SWAP_NR: res = fpx_int({v2[31:0], ~v3[63], v3[62:32]});
         `FPX_OP_AND: res = fpx_int(v2[63:0] & v3[63:0]);
         `FPX_OP_ANDCM: res = fpx_int(v2[63:0] & ~v3[63:0]);
         `FPX_OP_OR: res = fpx_int(v2[63:0] | v3[63:0]);
         `FPX_OP_XOR: res = fpx_int(v2[63:0] ^ v3[63:0]);
         `FPX_OP_SELECT: res = fpx_int((v3[63:0] & v2[63:0]) | (v4[63:0] & ~v2[63:0]));
         `FPX_OP_IMA_L, `FPX_OP_IMA_LU: res = fpx_int(ima_r[63:0]);
         `FPX_OP_IMA_H, `FPX_OP_IMA_HU: res = fpx_int(ima_r[127:64]);
         default: res = {nan_pick[81:63], 1'b1, nan_pick[61:0]};
      endcase
      if (nat_any) begin
         res = `FPX_NAT_VALUE;
      end
   end
   // ----------------------------------------------------------------
   // classify and flag check
   // ----------------------------------------------------------------
   wire cls_in = ((c2[1:0] & op_imm_i[1:0]) != 2'h0) && ((c2[7:2] & op_imm_i[7:2]) != 6'h0);
   wire cls_hit = (cls_in || (c2[8] && op_imm_i[8])) ^ op_imm_i[9];
   wire [5:0] alt_fl = fpx_f6(flags_q, op_sf_i);
   wire chk_trap = (alt_fl & traps_q) != 6'h0;
   wire chk_new = (alt_fl & ~flags_q[5:0]) != 6'h0;
   wire is_chk = (op_code_i == `FPX_OP_CHK_FLAGS);
   // ----------------------------------------------------------------
   // wishbone slave: one wait state, write lands with ack
   // ----------------------------------------------------------------
   wire wb_req = wb_cyc_i && wb_stb_i;
   wire wb_wr = wb_req && wb_we_i && ack_q;
   wire [81:0] rsel_v = rdv[rsel_q];
   always @* begin
      case (wb_adr_i)
         `FPX_OFF_TRAPS: rd_d = {26'h0, traps_q};
         `FPX_OFF_SF0: rd_d = {19'h0, flags_q[5:0], ctrl_q[6:0]};
         `FPX_OFF_SF1: rd_d = {19'h0, flags_q[11:6], ctrl_q[13:7]};
         `FPX_OFF_SF2: rd_d = {19'h0, flags_q[17:12], ctrl_q[20:14]};
         `FPX_OFF_SF3: rd_d = {19'h0, flags_q[23:18], ctrl_q[27:21]};
         `FPX_OFF_REG_SEL: rd_d = {29'h0, rsel_q};
         `FPX_OFF_REG_W0: rd_d = rsel_v[31:0];
         `FPX_OFF_REG_W1: rd_d = rsel_v[63:32];
         `FPX_OFF_REG_W2: rd_d = {14'h0, rsel_v[81:64]};
         `FPX_OFF_STATUS: rd_d = {29'h0, pred_q, fault_q, ~ready_q};
         default: rd_d = 32'h0;
      endcase
   end
   // ----------------------------------------------------------------
   // status field next values
   // ----------------------------------------------------------------
   wire [1:0] set_sf = idle ? op_sf_i : sf_q;
   wire [5:0] set_fl = idle ? ((accept && nan_cut && !nat_any && snan_any) ? `FPX_FLAG_INVALID : 6'h0)
                            : (arith_done_i ? arith_flags_i : 6'h0);
   wire [31:0] traps_w = fpx_be({26'h0, traps_q}, wb_dat_i, wb_sel_i);
   wire [31:0] rsel_w = fpx_be({29'h0, rsel_q}, wb_dat_i, wb_sel_i);
   integer k;
   reg [31:0] sfw;
   always @* begin
      sfw = 32'h0;
      traps_d = traps_q;
      ctrl_d = ctrl_q;
      flags_d = flags_q;
      for (k = 0; k < 4; k = k + 1) begin
         if (wb_wr && (wb_adr_i == `FPX_OFF_SF0 + k*4)) begin
            sfw = fpx_be({19'h0, flags_q[k*6 +: 6], ctrl_q[k*7 +: 7]}, wb_dat_i, wb_sel_i);
            ctrl_d[k*7 +: 7] = sfw[`FPX_SF_CTRL_LSB +: 7];
            flags_d[k*6 +: 6] = sfw[`FPX_SF_FLAG_LSB +: 6];
         end
         if (accept && (op_sf_i == k) && (op_code_i == `FPX_OP_SET_CTRL)) begin
            ctrl_d[k*7 +: 7] = (ctrl_q[6:0] & op_imm_i[6:0]) | op_imm_i[13:7];
         end
         if (accept && (op_sf_i == k) && (op_code_i == `FPX_OP_CLR_FLAGS)) begin
            flags_d[k*6 +: 6] = 6'h0;
         end
         // hardware set wins over any clear in the same cycle
         if (set_sf == k) begin
            flags_d[k*6 +: 6] = flags_d[k*6 +: 6] | set_fl;
         end
      end
      if (wb_wr && (wb_adr_i == `FPX_OFF_TRAPS)) begin
         traps_d = traps_w[5:0];
      end
   end
   // ----------------------------------------------------------------
   // register-bus and status flops
   // ----------------------------------------------------------------
   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0;
         rsel_q <= 3'h0;
         w0_q <= 32'h0;
         w1_q <= 32'h0;
         traps_q <= `FPX_TRAPS_RST;
         ctrl_q <= {4{`FPX_CTRL_RST}};
         flags_q <= 24'h0;
      end else begin
         ack_q <= wb_req && !ack_q;
         dat_q <= (wb_req && !ack_q && !wb_we_i) ? rd_d : 32'h0;
         traps_q <= traps_d;
         ctrl_q <= ctrl_d;
         flags_q <= flags_d;
         if (wb_wr && (wb_adr_i == `FPX_OFF_REG_SEL)) begin
            rsel_q <= rsel_w[2:0];
         end
         if (wb_wr && (wb_adr_i == `FPX_OFF_REG_W0)) begin
            w0_q <= fpx_be(w0_q, wb_dat_i, wb_sel_i);
         end
         if (wb_wr && (wb_adr_i == `FPX_OFF_REG_W1)) begin
            w1_q <= fpx_be(w1_q, wb_dat_i, wb_sel_i);
         end
      end
   end
   // ----------------------------------------------------------------
   // register file: bus commit first, engine write wins on a clash
   // ----------------------------------------------------------------
   wire eng_we = (accept && wr && !ar_go) || (state_q[1] && arith_done_i);
   wire [2:0] eng_idx = idle ? op_f1_i : dest_q;
   wire [81:0] eng_dat = idle ? res : arith_result_i;
   wire bus_we = wb_wr && (wb_adr_i == `FPX_OFF_REG_W2) && wb_sel_i[0];
   integer r;
   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (r = 2; r < 8; r = r + 1) begin
            fr_q[r] <= 82'h0;
         end
      end else begin
         for (r = 2; r < 8; r = r + 1) begin
            if (bus_we && (rsel_q == r)) begin
               fr_q[r] <= {wb_dat_i[17:0], w1_q, w0_q};
            end
            if (eng_we && (eng_idx == r)) begin
               fr_q[r] <= eng_dat;
            end
         end
      end
   end
   // ----------------------------------------------------------------
   // issue engine
   // ----------------------------------------------------------------
   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q <= ST_IDLE;
         ready_q <= 1'b1;
         done_q <= 1'b0;
         fault_q <= 1'b0;
         pred_q <= 1'b0;
         av_q <= 1'b0;
         kind_q <= `FPX_K_MA;
         pk_q <= 1'b0;
         a_q <= 82'h0;
         b_q <= 82'h0;
         c_q <= 82'h0;
         sf_q <= 2'h0;
         dest_q <= 3'h0;
         actl_q <= 7'h00;
      end else begin
         done_q <= 1'b0;
         fault_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (op_valid_i) begin
                  done_q <= !ar_go;
                  fault_q <= is_chk && (chk_trap || chk_new);
                  if (op_code_i == `FPX_OP_CLASS) begin
                     pred_q <= cls_hit;
                  end
                  if (ar_go) begin
                     state_q <= ST_ARITH;
                     ready_q <= 1'b0;
                     av_q <= 1'b1;
                     kind_q <= kind;
                     pk_q <= pk;
                     a_q <= v3;
                     b_q <= v4;
                     c_q <= v2;
                     sf_q <= op_sf_i;
                     actl_q <= fpx_f7(ctrl_q, op_sf_i);
                     dest_q <= op_f1_i;
                  end
               end
            end
            ST_ARITH: begin
               if (arith_done_i) begin
                  state_q <= ST_IDLE;
                  ready_q <= 1'b1;
                  av_q <= 1'b0;
                  done_q <= 1'b1;
               end
            end
            default: begin
               state_q <= ST_IDLE;
               ready_q <= 1'b1;
               av_q <= 1'b0;
            end
         endcase
      end
   end
   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign op_ready_o = ready_q;
   assign op_done_o = done_q;
   assign op_fault_o = fault_q;
   assign op_pred_o = pred_q;
   assign arith_valid_o = av_q;
   assign arith_kind_o = kind_q;
   assign arith_packed_o = pk_q;
   assign arith_a_o = a_q;
   assign arith_b_o = b_q;
   assign arith_c_o = c_q;
   assign arith_sf_o = sf_q;
   assign arith_ctrl_o = actl_q;
endmodule
`default_nettype wire

// file: verif/fpx_arith_model.sv
// arithmetic unit stand-in answering fused multiply-add requests
`timescale 1ns/100ps
`default_nettype none
module fpx_arith_model (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic valid_i,
   input wire logic [7:0] lat_i,
   input wire logic [81:0] res_i,
   output logic done_o,
   output logic [81:0] result_o,
   output logic [5:0] flags_o
);
   logic [7:0] cnt_q;
   // outside the answer cycle the lines carry junk, never the real value
   assign result_o = done_o ? res_i : ~res_i;
   assign flags_o = done_o ? 6'h02 : 6'h3D;
   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_q <= 8'h00;
         done_o <= 1'b0;
      end else begin
         done_o <= valid_i && cnt_q == lat_i;
         cnt_q <= !valid_i ? 8'h00 : (cnt_q == 8'hFF ? cnt_q : cnt_q + 8'h01);
      end
   end
endmodule
`default_nettype wire

// file: verif/fpx_unit_sva.sv
// concurrent checks on the execution unit ports
`include "fpx_map.vh"
`timescale 1ns/100ps
`default_nettype none
module fpx_unit_sva (
   input wire clock_i,
   input wire resetn_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_ack_o,
   input wire [31:0] wb_dat_o,
   input wire op_valid_i,
   input wire op_ready_o,
   input wire [5:0] op_code_i,
   input wire op_done_o,
   input wire op_fault_o,
   input wire arith_valid_o,
   input wire [1:0] arith_kind_o,
   input wire [81:0] arith_a_o,
   input wire [81:0] arith_b_o,
   input wire [81:0] arith_c_o,
   input wire [1:0] arith_sf_o,
   input wire arith_done_i
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   wire take = op_valid_i && op_ready_o;
   a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus ack missing");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("dat not zero");
   a_fault_done: assert property (op_fault_o |-> op_done_o)
      else $error("fault without done");
   a_arith_hold: assert property (arith_valid_o && !arith_done_i |=> arith_valid_o &&
      $stable(arith_a_o) && $stable(arith_c_o) && $stable(arith_sf_o)) else $error("arith moved");
   a_arith_end: assert property (arith_valid_o && arith_done_i |=> op_done_o && !arith_valid_o)
      else $error("arith end wrong");
   a_mpy_addend: assert property (take && op_code_i == `FPX_OP_MPY |=>
      arith_valid_o && arith_c_o == `FPX_ZERO) else $error("mpy addend");
   a_add_mult: assert property (take && op_code_i == `FPX_OP_ADD |=>
      arith_valid_o && arith_b_o == `FPX_ONE) else $error("add multiplicand");
   a_norm_ops: assert property (take && op_code_i == `FPX_OP_NORM |=> arith_b_o == `FPX_ONE
      && arith_c_o == `FPX_ZERO && arith_kind_o == `FPX_K_MA) else $error("norm operands");
   a_logic_fast: assert property (take && op_code_i == `FPX_OP_AND |=> op_done_o && op_ready_o)
      else $error("logic op slow");
   cover property (arith_valid_o && arith_done_i);
   cover property (op_fault_o);
   cover property (wb_ack_o);
endmodule
`default_nettype wire

// file: verif/fpx_unit_test.sv
// self-checking bench for the execution unit
`include "fpx_map.vh"
`timescale 1ns/100ps
`default_nettype none
module fpx_unit_test;
   logic clock_i = 0, resetn_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, op_valid_i = 0, flt;
   logic [7:0] wb_adr_i = 8'h00, lat = 8'h00;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, q;
   logic [5:0] op_code_i = 6'h00;
   logic [2:0] op_f1_i = 3'h0, op_f2_i = 3'h0, op_f3_i = 3'h0, op_f4_i = 3'h0;
   logic [1:0] op_sf_i = 2'h0;
   logic [13:0] op_imm_i = 14'h0;
   logic [81:0] res = {1'b0, 17'h0FFFF, 64'hC000000000000000}, v, a, b;
   wire [31:0] wb_dat_o;
   wire wb_ack_o, op_ready_o, op_done_o, op_fault_o, op_pred_o, arith_valid_o, arith_packed_o;
   wire arith_done_i;
   wire [1:0] arith_kind_o, arith_sf_o;
   wire [81:0] arith_a_o, arith_b_o, arith_c_o, arith_result_i;
   wire [6:0] arith_ctrl_o;
   wire [5:0] arith_flags_i;
   int n_errors = 0, n_checks = 0;
   logic [5:0] cs[4];
   logic [63:0] es[4];
   fpx_unit i_dut (.*);
   fpx_arith_model i_arith (.clock_i, .resetn_i, .valid_i(arith_valid_o), .lat_i(lat),
      .res_i(res), .done_o(arith_done_i), .result_o(arith_result_i), .flags_o(arith_flags_i));
   always #25 clock_i = ~clock_i;
   task chk(input string s, input logic [81:0] e, g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask
   task wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      @(posedge clock_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, ad, d};
      do @(posedge clock_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask
   task wreg(input logic [2:0] i, input logic [81:0] x);
      wb(1, `FPX_OFF_REG_SEL, {29'h0, i});
      wb(1, `FPX_OFF_REG_W0, x[31:0]);
      wb(1, `FPX_OFF_REG_W1, x[63:32]);
      wb(1, `FPX_OFF_REG_W2, {14'h0, x[81:64]});
   endtask
   task rreg(input logic [2:0] i);
      wb(1, `FPX_OFF_REG_SEL, {29'h0, i});
      wb(0, `FPX_OFF_REG_W0, 0);
      v[31:0] = q;
      wb(0, `FPX_OFF_REG_W1, 0);
      v[63:32] = q;
      wb(0, `FPX_OFF_REG_W2, 0);
      v[81:64] = q[17:0];
   endtask
   task op(input logic [5:0] c, input logic [2:0] d, f2, f3, f4, input logic [1:0] s,
      input logic [13:0] m);
      @(posedge clock_i);
      {op_valid_i, op_code_i, op_f1_i, op_f2_i, op_f3_i, op_f4_i, op_sf_i, op_imm_i} <=
         {1'b1, c, d, f2, f3, f4, s, m};
      do @(posedge clock_i); while (op_ready_o !== 1'b1);
      op_valid_i <= 1'b0;
      do @(posedge clock_i); while (op_done_o !== 1'b1);
      flt = op_fault_o;
   endtask
   task tally_and_finish;
      if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clock_i);
      n_errors++;
      tally_and_finish;
   end
   initial begin
      a = {1'b1, 17'h1003E, 64'hF0F0123456789ABC};
      b = {1'b0, 17'h1003E, 64'hFF00FF000F0F3C3C};
      repeat (12) @(posedge clock_i);
      resetn_i <= 1'b1;
      wb(0, `FPX_OFF_SF0, 0);
      chk("sf0", 0, 82'(q));
      wb(0, 8'hFC, 0);
      chk("unmapped", 0, 82'(q));
      wreg(1, 0);
      rreg(1);
      chk("reg1", `FPX_ONE, v);
      rreg(0);
      chk("reg0", `FPX_ZERO, v);
      wreg(2, a);
      wreg(3, b);
      es = '{a[63:0] & b[63:0], a[63:0] & ~b[63:0], a[63:0] | b[63:0], a[63:0] ^ b[63:0]};
      for (int i = 0; i < 4; i++) begin
         op(`FPX_OP_AND + 6'(i), 4, 2, 3, 0, 0, 0);
         rreg(4);
         chk("logic", 82'(es[i]), 82'(v[63:0]));
      end
      cs = '{`FPX_OP_ABS, `FPX_OP_NEG, `FPX_OP_NEGABS, `FPX_OP_MRG_SIGN_EXP};
      for (int i = 0; i < 4; i++) begin
         op(cs[i], 4, i == 3 ? 3'h3 : 3'h2, 2, 2, 0, 0);
         rreg(4);
         chk("merge", i == 3 ? {b[81:64], a[63:0]} : {i == 2, a[80:0]}, v);
      end
      op(`FPX_OP_PACK, 5, 1, 1, 1, 0, 0);
      rreg(5);
      chk("pack", {1'b0, `FPX_EXP_INT, 64'h3F8000003F800000}, v);
      wreg(2, {1'b1, 17'h00123, 64'hFFFFFFFFFFFFFFFF});
      wreg(3, {1'b0, 17'h0FFFF, 64'h2});
      wreg(4, {1'b1, 17'h1003E, 64'h5});
      es = '{64'h3, 64'h0, 64'h3, 64'h2};
      for (int i = 0; i < 4; i++) begin
         op(`FPX_OP_IMA_L + 6'(i), 6, 4, 2, 3, 0, 0);
         rreg(6);
         chk("ima", {1'b0, `FPX_EXP_INT, es[i]}, v);
      end
      wb(1, `FPX_OFF_SF1, 32'h200);
      op(`FPX_OP_CHK_FLAGS, 0, 0, 0, 0, 1, 0);
      chk("fault", 1, 82'(flt));
      wb(1, `FPX_OFF_SF0, 32'h200);
      op(`FPX_OP_CHK_FLAGS, 0, 0, 0, 0, 1, 0);
      chk("fault", 0, 82'(flt));
      wb(0, `FPX_OFF_SF1, 0);
      chk("sf1", 82'h200, 82'(q));
      wb(1, `FPX_OFF_TRAPS, 32'h4);
      op(`FPX_OP_CHK_FLAGS, 0, 0, 0, 0, 1, 0);
      chk("fault", 1, 82'(flt));
      wb(1, `FPX_OFF_SF0, 32'h55);
      op(`FPX_OP_SET_CTRL, 0, 0, 0, 0, 2, {7'h20, 7'h0F});
      wb(0, `FPX_OFF_SF2, 0);
      chk("ctrl", 82'h25, 82'(q[6:0]));
      op(`FPX_OP_CLR_FLAGS, 0, 0, 0, 0, 1, 0);
      wb(0, `FPX_OFF_SF1, 0);
      chk("clear", 0, 82'(q[12:7]));
      cs = '{`FPX_OP_MPY, `FPX_OP_ADD, `FPX_OP_SUB, `FPX_OP_NORM};
      for (int i = 0; i < 4; i++) begin
         lat <= 8'(i * 3);
         op(cs[i], 7, 2, 3, 4, 3, 0);
         rreg(7);
         chk("arith", res, v);
      end
      wb(0, `FPX_OFF_SF3, 0);
      chk("sf3 flags", 82'h02, 82'(q[12:7]));
      wreg(5, {1'b0, `FPX_EXP_MAX, 64'h8000000000000001});
      wreg(6, {1'b0, `FPX_EXP_MAX, 64'hC000000000000002});
      op(`FPX_OP_FMA, 7, 6, 6, 5, 0, 0);
      rreg(7);
      chk("nan f4", {1'b0, `FPX_EXP_MAX, 64'hC000000000000001}, v);
      wb(0, `FPX_OFF_SF0, 0);
      chk("invalid", 82'h01, 82'(q[12:7]));
      op(`FPX_OP_FMA, 7, 6, 5, 4, 0, 0);
      rreg(7);
      chk("nan f2", {1'b0, `FPX_EXP_MAX, 64'hC000000000000002}, v);
      op(`FPX_OP_CLASS, 0, 5, 0, 0, 0, 14'h041);
      chk("class", 1, 82'(op_pred_o));
      op(`FPX_OP_SELECT, 4, 3, 4, 2, 0, 0);
      rreg(4);
      chk("select", {1'b0, `FPX_EXP_INT, 64'hFFFFFFFFFFFFFFFD}, v);
      tally_and_finish;
   end
endmodule
bind fpx_unit fpx_unit_sva i_sva (.*);
`default_nettype wire
